// ===== hw/pfp_pkg.sv
// shared constants and types of the program flow and pointer unit
package pfp_pkg;
  localparam logic [7:0]  REG_TABLE_HIGH_LATCH = 8'h82;
  localparam logic [7:0]  REG_INDEX_LOW        = 8'h83;
  localparam logic [7:0]  REG_INDEX_HIGH       = 8'h84;
  localparam logic [7:0]  REG_ALU_FLAGS        = 8'h86;
  localparam logic [7:0]  REG_LOC_LOW_HALF     = 8'hce;
  localparam logic [7:0]  REG_LOC_HIGH_HALF    = 8'hcf;
  localparam logic [7:0]  REG_STACK_POINTER    = 8'hdf;
  localparam logic [7:0]  REG_INDEXED_CELL     = 8'he7;
  localparam int          FLAG_CARRY_BIT       = 2;
  localparam int          FLAG_ZERO_BIT        = 0;
  localparam logic [7:0]  FLAGS_MASK           = 8'h05;
  localparam logic [10:0] LOC_RESET            = 11'h000;
  localparam logic [7:0]  FLAGS_RESET          = 8'h00;
  localparam logic [7:0]  DATA_RESET           = 8'h00;
  localparam logic [1:0]  SP_RESET             = 2'h3;
  localparam logic [10:0] LOC_STEP             = 11'h001;
  localparam logic [10:0] LOC_SKIP_STEP        = 11'h002;
  localparam int          STACK_LEVELS         = 4;

  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_JUMP       = 5'h01,
    OP_CALL       = 5'h02,
    OP_RET        = 5'h03,
    OP_MOV_A_IMM  = 5'h04,
    OP_MOV_A_MEM  = 5'h05,
    OP_MOV_MEM_A  = 5'h06,
    OP_MOV_MEM_IMM = 5'h07,
    OP_CMP_SKIP_IMM = 5'h08,
    OP_CMP_SKIP_MEM = 5'h09,
    OP_INC_MEM_SKIP = 5'h0a,
    OP_DEC_MEM_SKIP = 5'h0b,
    OP_SKIP_IF_SET  = 5'h0c,
    OP_SKIP_IF_CLR  = 5'h0d,
    OP_ADD_MEM_A  = 5'h0e,
    OP_SUB_MEM_A  = 5'h0f,
    OP_ROT_LEFT   = 5'h10,
    OP_TABLE_FETCH = 5'h11
  } pfp_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MEM_RD = 2'b01,
    ST_ROM_RD = 2'b10
  } pfp_state_t;

  typedef struct packed {
    logic        valid;
    pfp_op_t     op;
    logic        indirect;
    logic [7:0]  addr;
    logic [7:0]  imm;
    logic [2:0]  bit_sel;
    logic [10:0] target;
  } pfp_req_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pfp_ram_t;
endpackage

// ===== hw/pfp_core.sv
// program flow, status flags, index pointers, table latch and return stack
// Function
// RULE1: carry set on add carry, no borrow, rotate-out one, compare >= 0
// RULE2: zero flag set when arithmetic, logic or branch result is zero; here only memory-to-accumulator move, compare, add and subtract update zero
// RULE3: fetch location is 11 bits, 3-bit high half and 8-bit low half
// RULE4: fetch location advances by one per executed instruction
// RULE5: jump and call load the full 11-bit destination
// RULE6: a true skip condition advances the fetch location by two
// RULE7: bit-test skips on one or zero as the opcode selects
// RULE8: compare-skip skips when accumulator equals the operand
// RULE9: increment-skip writes back and skips on wrap to zero
// RULE10: decrement-skip writes back and skips on wrap from zero
// RULE11: writing the low half jumps to the resulting address at once
// RULE12: carry out of an add into the low half increments the high half
// RULE13: borrow from the low half leaves the high half unchanged
// RULE14: both index registers are 8-bit read/write working registers
// RULE15: indexed cell reaches bank from high index, offset from low index
// RULE16: table fetch uses both index registers as program address
// RULE17: table fetch puts high byte in latch, low byte in accumulator
// RULE18: table latch is an 8-bit read/write working register
// RULE19: immediate operand goes to accumulator or a RAM location
// RULE20: direct mode moves bytes between accumulator and bank 0
// RULE21: indirect mode addresses memory through the index registers
// RULE22: four-level return stack saves and restores the fetch location
// RULE23: reset clears the fetch location to address zero
// RULE24: push decrements the stack pointer, pop increments it
// RULE25: a skip leaves flags and stack pointer untouched; compare-skip here still updates carry and zero
module pfp_core
  import pfp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire pfp_req_t    req,
  output logic             ready,
  input  wire logic [7:0]  ram_rdata,
  output pfp_ram_t         ram,
  output logic             rom_rd,
  output logic [15:0]      rom_addr,
  input  wire logic [15:0] rom_word,
  output logic [10:0]      fetch_location,
  output logic [7:0]       accumulator,
  output logic [7:0]       alu_flags,
  output logic [7:0]       index_low,
  output logic [7:0]       index_high,
  output logic [7:0]       table_high_latch,
  output logic [1:0]       stack_pointer
);

  function automatic logic needs_mem(input pfp_op_t op);
    unique case (op)
      OP_MOV_A_MEM, OP_MOV_MEM_A, OP_MOV_MEM_IMM, OP_CMP_SKIP_MEM, OP_INC_MEM_SKIP,
      OP_DEC_MEM_SKIP, OP_SKIP_IF_SET, OP_SKIP_IF_CLR, OP_ADD_MEM_A, OP_SUB_MEM_A,
      OP_ROT_LEFT: needs_mem = 1'b1;
      default: needs_mem = 1'b0;
    endcase
  endfunction

  function automatic logic is_sys(input logic [15:0] a);
    if (a[15:8] != 8'h00) begin
      is_sys = 1'b0;
    end else begin
      unique case (a[7:0])
        REG_TABLE_HIGH_LATCH, REG_INDEX_LOW, REG_INDEX_HIGH, REG_ALU_FLAGS,
        REG_LOC_LOW_HALF, REG_LOC_HIGH_HALF, REG_STACK_POINTER: is_sys = 1'b1;
        default: is_sys = 1'b0;
      endcase
    end
  endfunction

  pfp_state_t  state_reg;
  pfp_req_t    cur_reg;
  logic [15:0] eff_reg;
  logic [10:0] stack_mem [STACK_LEVELS];

  // effective address of the incoming request
  logic [15:0] eff_next;
  always_comb begin
    if (req.indirect || req.addr == REG_INDEXED_CELL) begin
      eff_next = {index_high, index_low}; // [RULE15] [RULE21]
    end else begin
      eff_next = {8'h00, req.addr}; // [RULE20]
    end
  end

  logic accept;
  logic exec;
  assign accept = ready && req.valid;
  assign exec   = (accept && !needs_mem(req.op) && req.op != OP_TABLE_FETCH)
                  || state_reg == ST_MEM_RD || state_reg == ST_ROM_RD;

  pfp_req_t    x;
  logic [15:0] xa;
  assign x  = (state_reg == ST_IDLE) ? req : cur_reg;
  assign xa = eff_reg;

  // operand fetched from internal register or RAM
  logic [7:0] mem_b;
  always_comb begin
    mem_b = ram_rdata;
    if (is_sys(xa)) begin
      unique case (xa[7:0])
        REG_TABLE_HIGH_LATCH: mem_b = table_high_latch;
        REG_INDEX_LOW:        mem_b = index_low;
        REG_INDEX_HIGH:       mem_b = index_high;
        REG_ALU_FLAGS:        mem_b = alu_flags;
        REG_LOC_LOW_HALF:     mem_b = fetch_location[7:0];
        REG_LOC_HIGH_HALF:    mem_b = {5'h00, fetch_location[10:8]};
        default:              mem_b = {6'h00, stack_pointer};
      endcase
    end
  end

  // instruction result
  logic [8:0]  sum;
  logic [7:0]  res;
  logic        wr_res;
  logic        skip;
  logic        set_c;
  logic        set_z;
  logic        c_val;
  logic [7:0]  cmp_b;
  always_comb begin
    sum    = 9'h000;
    res    = 8'h00;
    wr_res = 1'b0;
    skip   = 1'b0;
    set_c  = 1'b0;
    set_z  = 1'b0;
    c_val  = 1'b0;
    cmp_b  = (x.op == OP_CMP_SKIP_IMM) ? x.imm : mem_b;
    unique case (x.op)
      OP_MOV_A_MEM: set_z = 1'b1; // [RULE2]
      OP_MOV_MEM_A: begin
        res    = accumulator;
        wr_res = 1'b1;
      end
      OP_MOV_MEM_IMM: begin
        res    = x.imm; // [RULE19]
        wr_res = 1'b1;
      end
      OP_CMP_SKIP_IMM, OP_CMP_SKIP_MEM: begin
        sum   = {1'b0, accumulator} - {1'b0, cmp_b};
        set_c = 1'b1;
        set_z = 1'b1;
        c_val = !sum[8]; // [RULE1]
        skip  = accumulator == cmp_b; // [RULE8]
      end
      OP_INC_MEM_SKIP: begin
        res    = mem_b + 8'h01;
        wr_res = 1'b1;
        skip   = mem_b == 8'hff; // [RULE9]
      end
      OP_DEC_MEM_SKIP: begin
        res    = mem_b - 8'h01;
        wr_res = 1'b1;
        skip   = mem_b == 8'h00; // [RULE10]
      end
      OP_SKIP_IF_SET: skip = mem_b[x.bit_sel]; // [RULE7]
      OP_SKIP_IF_CLR: skip = !mem_b[x.bit_sel]; // [RULE7]
      OP_ADD_MEM_A: begin
        sum    = {1'b0, mem_b} + {1'b0, accumulator};
        res    = sum[7:0];
        wr_res = 1'b1;
        set_c  = 1'b1;
        set_z  = 1'b1;
        c_val  = sum[8]; // [RULE1]
      end
      OP_SUB_MEM_A: begin
        sum    = {1'b0, mem_b} - {1'b0, accumulator};
        res    = sum[7:0];
        wr_res = 1'b1;
        set_c  = 1'b1;
        set_z  = 1'b1;
        c_val  = !sum[8]; // [RULE1]
      end
      OP_ROT_LEFT: begin
        res    = {mem_b[6:0], alu_flags[FLAG_CARRY_BIT]};
        wr_res = 1'b1;
        set_c  = 1'b1;
        c_val  = mem_b[7]; // [RULE1]
      end
      default: ;
    endcase
  end

  logic [7:0] z_src;
  assign z_src = (x.op == OP_MOV_A_MEM) ? mem_b
               : (x.op == OP_CMP_SKIP_IMM || x.op == OP_CMP_SKIP_MEM) ? sum[7:0] : res;

  logic sys_wr;
  assign sys_wr = exec && wr_res && is_sys(xa);

  // sequencing of multi-cycle requests
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      ready     <= 1'b1;
      cur_reg   <= '0;
      eff_reg   <= 16'h0000;
      rom_rd    <= 1'b0;
      rom_addr  <= 16'h0000;
    end else begin
      rom_rd <= 1'b0;
      if (state_reg != ST_IDLE) begin
        state_reg <= ST_IDLE;
        ready     <= 1'b1;
      end else if (accept && needs_mem(req.op)) begin
        state_reg <= ST_MEM_RD;
        ready     <= 1'b0;
        cur_reg   <= req;
        eff_reg   <= eff_next;
      end else if (accept && req.op == OP_TABLE_FETCH) begin
        state_reg <= ST_ROM_RD;
        ready     <= 1'b0;
        cur_reg   <= req;
        rom_rd    <= 1'b1;
        rom_addr  <= {index_high, index_low}; // [RULE16]
      end
    end
  end

  // external RAM strobes; system register addresses never reach RAM
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ram <= '0;
    end else begin
      ram.rd <= accept && needs_mem(req.op) && !is_sys(eff_next);
      ram.wr <= exec && wr_res && !is_sys(xa);
      if (accept && needs_mem(req.op)) begin
        ram.addr <= eff_next;
      end
      if (exec && wr_res) begin
        ram.wdata <= res;
      end
    end
  end

  // fetch location
  logic [10:0] loc_seq;
  assign loc_seq = fetch_location + LOC_STEP;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_location <= LOC_RESET; // [RULE23]
    end else if (exec) begin
      if (x.op == OP_JUMP || x.op == OP_CALL) begin
        fetch_location <= x.target; // [RULE5] [RULE3]
      end else if (x.op == OP_RET) begin
        fetch_location <= stack_mem[~(stack_pointer + 2'h1)]; // [RULE22]
      end else if (sys_wr && xa[7:0] == REG_LOC_LOW_HALF) begin
        // only an add carries upward; a borrow never reaches the high half
        fetch_location[7:0]  <= res; // [RULE11] [RULE13]
        fetch_location[10:8] <= fetch_location[10:8]
                                + {2'h0, x.op == OP_ADD_MEM_A && sum[8]}; // [RULE12]
      end else if (sys_wr && xa[7:0] == REG_LOC_HIGH_HALF) begin
        fetch_location <= {res[2:0], fetch_location[7:0]} + LOC_STEP;
      end else if (skip) begin
        fetch_location <= fetch_location + LOC_SKIP_STEP; // [RULE6]
      end else begin
        fetch_location <= loc_seq; // [RULE4]
      end
    end
  end

  // return stack; pointer starts at level three
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stack_pointer <= SP_RESET;
    end else if (exec && x.op == OP_CALL) begin
      stack_pointer <= stack_pointer - 2'h1; // [RULE24]
    end else if (exec && x.op == OP_RET) begin
      stack_pointer <= stack_pointer + 2'h1; // [RULE24]
    end else if (sys_wr && xa[7:0] == REG_STACK_POINTER) begin
      stack_pointer <= res[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (exec && x.op == OP_CALL) begin
      stack_mem[~stack_pointer] <= loc_seq; // [RULE22]
    end
  end

  // carry and zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alu_flags <= FLAGS_RESET;
    end else if (sys_wr && xa[7:0] == REG_ALU_FLAGS) begin
      alu_flags <= res & FLAGS_MASK;
    end else if (exec) begin
      if (set_c) begin
        alu_flags[FLAG_CARRY_BIT] <= c_val; // [RULE1] [RULE25]
      end
      if (set_z) begin
        alu_flags[FLAG_ZERO_BIT] <= z_src == 8'h00; // [RULE2]
      end
    end
  end

  // accumulator, index registers and table latch
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      accumulator      <= DATA_RESET;
      index_low        <= DATA_RESET;
      index_high       <= DATA_RESET;
      table_high_latch <= DATA_RESET;
    end else if (state_reg == ST_ROM_RD) begin
      table_high_latch <= rom_word[15:8]; // [RULE17]
      accumulator      <= rom_word[7:0]; // [RULE17]
    end else if (exec) begin
      if (x.op == OP_MOV_A_IMM) begin
        accumulator <= x.imm; // [RULE19]
      end else if (x.op == OP_MOV_A_MEM) begin
        accumulator <= mem_b; // [RULE20]
      end
      if (sys_wr && xa[7:0] == REG_INDEX_LOW) begin
        index_low <= res; // [RULE14]
      end
      if (sys_wr && xa[7:0] == REG_INDEX_HIGH) begin
        index_high <= res; // [RULE14]
      end
      if (sys_wr && xa[7:0] == REG_TABLE_HIGH_LATCH) begin
        table_high_latch <= res; // [RULE18]
      end
    end
  end

  jump_load_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE5]
    exec && x.op == OP_JUMP |=> fetch_location == $past(x.target))
    else $error("jump did not load destination");

  seq_step_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE4]
    exec && x.op == OP_MOV_A_IMM |=> fetch_location == $past(fetch_location) + LOC_STEP)
    else $error("sequential step not one");

  bit_skip_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE7]
    exec && x.op == OP_SKIP_IF_SET && mem_b[x.bit_sel] && !is_sys(xa)
    |=> fetch_location == $past(fetch_location) + LOC_SKIP_STEP)
    else $error("bit set did not skip");

  cmp_flags_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE1]
    exec && x.op == OP_CMP_SKIP_IMM
    |=> alu_flags[FLAG_CARRY_BIT] == ($past(accumulator) >= $past(x.imm))
        && alu_flags[FLAG_ZERO_BIT] == ($past(accumulator) == $past(x.imm)))
    else $error("compare flags wrong");

  call_push_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE24]
    exec && x.op == OP_CALL |=> stack_pointer == $past(stack_pointer) - 2'h1)
    else $error("push did not decrement pointer");

  call_ret_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE22]
    exec && x.op == OP_CALL ##1 (exec && x.op == OP_RET)
    |=> fetch_location == $past(fetch_location, 2) + LOC_STEP)
    else $error("return address lost");

  rom_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE16]
    accept && req.op == OP_TABLE_FETCH
    |=> rom_rd && rom_addr == {$past(index_high), $past(index_low)} ##1 state_reg == ST_IDLE)
    else $error("table fetch address wrong");

  table_load_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE17]
    state_reg == ST_ROM_RD |=> table_high_latch == $past(rom_word[15:8])
                               && accumulator == $past(rom_word[7:0]))
    else $error("table fetch bytes misplaced");

  skip_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE25]
    exec && (x.op == OP_SKIP_IF_CLR || x.op == OP_INC_MEM_SKIP) && !is_sys(xa)
    |=> $stable(alu_flags) && $stable(stack_pointer))
    else $error("skip disturbed flags");

endmodule

// ===== test/pfp_mem_model.sv
// behavioural data ram and program rom on the far side of the flow unit
module pfp_mem_model
  import pfp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire pfp_ram_t    ram,
  output logic [7:0]       ram_rdata,
  input  wire logic        rom_rd,
  input  wire logic [15:0] rom_addr,
  output logic [15:0]      rom_word,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] junk = 8'h5a;
  // outside a read cycle the data changes every clock, so stale bytes never match
  always @(posedge ref_clk) begin
    junk <= junk + 8'h3b;
    if (ram.wr) begin
      mem[ram.addr[7:0]] <= ram.wdata;
      wr_addr <= ram.addr;
      wr_data <= ram.wdata;
    end
  end
  assign ram_rdata = ram.rd ? mem[ram.addr[7:0]] : junk;
  // rom word follows from its address so the bench can predict it
  assign rom_word = rom_rd ? {~rom_addr[7:0], rom_addr[15:8] ^ rom_addr[7:0]} : {junk, ~junk};
endmodule

// ===== test/program_flow_and_pointers_test.sv
// self-checking bench of the program flow and pointer unit
module program_flow_and_pointers_test;
  import pfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  pfp_req_t    req = '0;
  logic        ready, rom_rd;
  logic [7:0]  ram_rdata, accumulator, alu_flags, index_low, index_high, table_high_latch;
  logic [7:0]  wr_data;
  logic [15:0] rom_addr, rom_word, wr_addr, seen_rom;
  logic [10:0] fetch_location;
  logic [1:0]  stack_pointer;
  pfp_ram_t    ram;
  int          n_fail = 0;
  int          comparisons = 0;

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rom_rd) seen_rom <= rom_addr;

  pfp_core i_pfp_core (
    .ref_clk          (ref_clk),
    .nrst             (nrst),
    .req              (req),
    .ready            (ready),
    .ram_rdata        (ram_rdata),
    .ram              (ram),
    .rom_rd           (rom_rd),
    .rom_addr         (rom_addr),
    .rom_word         (rom_word),
    .fetch_location   (fetch_location),
    .accumulator      (accumulator),
    .alu_flags        (alu_flags),
    .index_low        (index_low),
    .index_high       (index_high),
    .table_high_latch (table_high_latch),
    .stack_pointer    (stack_pointer)
  );
  pfp_mem_model i_pfp_mem_model (
    .ref_clk   (ref_clk),
    .ram       (ram),
    .ram_rdata (ram_rdata),
    .rom_rd    (rom_rd),
    .rom_addr  (rom_addr),
    .rom_word  (rom_word),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 8 && ready !== 1'b1; i++) @(negedge ref_clk);
    if (ready !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask

  // one request, held until taken, then released; returns once results have landed
  task automatic op(input pfp_op_t code, input logic [7:0] a = 8'h00,
                    input logic [7:0] imm = 8'h00, input logic [10:0] tgt = 11'h000,
                    input logic ind = 1'b0, input logic [2:0] b = 3'h0);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, op: code, indirect: ind, addr: a, imm: imm, bit_sel: b,
             target: tgt};
    @(negedge ref_clk);
    wait_ready();
    @(posedge ref_clk);
    req.valid <= 1'b0;
    @(negedge ref_clk);
    wait_ready();
    // the ram strobe lands in the model one edge after execution
    @(negedge ref_clk);
  endtask

  task automatic stepped(input pfp_op_t code, input logic [7:0] a, input logic [2:0] b,
                         input logic [10:0] step);
    logic [10:0] loc;
    logic [7:0]  fl;
    logic [1:0]  sp;
    loc = fetch_location;
    fl = alu_flags;
    sp = stack_pointer;
    op(code, a, 8'h00, 11'h000, 1'b0, b);
    check("fetch_location", fetch_location, loc + step);
    check("alu_flags", alu_flags, fl);
    check("stack_pointer", stack_pointer, sp);
  endtask

  task automatic t_reset();
    check("fetch_location", fetch_location, 16'h0000);
    check("stack_pointer", stack_pointer, 16'h0003);
    check("alu_flags", alu_flags, 16'h0000);
  endtask

  task automatic t_jump();
    op(OP_JUMP, .tgt(11'h7fe));
    check("fetch_location", fetch_location, 16'h07fe);
    op(OP_NOP);
    check("fetch_location", fetch_location, 16'h07ff);
    op(OP_NOP);
    check("fetch_location", fetch_location, 16'h0000);
  endtask

  task automatic t_compare();
    logic [10:0] loc;
    op(OP_MOV_A_IMM, .imm(8'h12));
    check("accumulator", accumulator, 16'h0012);
    loc = fetch_location;
    op(OP_CMP_SKIP_IMM, .imm(8'h12));
    check("fetch_location", fetch_location, loc + 11'h2);
    check("alu_flags", alu_flags, 16'h0005);
    op(OP_CMP_SKIP_IMM, .imm(8'h13));
    check("fetch_location", fetch_location, loc + 11'h3);
    check("alu_flags", alu_flags, 16'h0000);
    op(OP_CMP_SKIP_IMM, .imm(8'h11));
    check("alu_flags", alu_flags, 16'h0004);
    op(OP_MOV_MEM_IMM, 8'h22, 8'h12);
    loc = fetch_location;
    op(OP_CMP_SKIP_MEM, 8'h22);
    check("fetch_location", fetch_location, loc + 11'h2);
    check("alu_flags", alu_flags, 16'h0005);
  endtask

  task automatic t_skips();
    op(OP_MOV_MEM_IMM, 8'h20, 8'hff);
    check("ram write", wr_addr, 16'h0020);
    stepped(OP_INC_MEM_SKIP, 8'h20, 3'h0, 11'h2);
    check("ram data", wr_data, 16'h0000);
    stepped(OP_INC_MEM_SKIP, 8'h20, 3'h0, 11'h1);
    stepped(OP_DEC_MEM_SKIP, 8'h20, 3'h0, 11'h1);
    stepped(OP_DEC_MEM_SKIP, 8'h20, 3'h0, 11'h2);
    check("ram data", wr_data, 16'h00ff);
    op(OP_MOV_MEM_IMM, 8'h20, 8'ha5);
    for (int b = 0; b < 8; b++) begin
      stepped(OP_SKIP_IF_SET, 8'h20, 3'(b), (8'ha5 >> b) & 1 ? 11'h2 : 11'h1);
      stepped(OP_SKIP_IF_CLR, 8'h20, 3'(b), (8'ha5 >> b) & 1 ? 11'h1 : 11'h2);
    end
  endtask

  task automatic t_alu();
    op(OP_MOV_MEM_IMM, 8'h21, 8'h3c);
    op(OP_MOV_A_MEM, 8'h21);
    check("accumulator", accumulator, 16'h003c);
    check("alu_flags", alu_flags & 8'h01, 16'h0000);
    op(OP_MOV_MEM_IMM, 8'h21, 8'h01);
    op(OP_MOV_A_IMM, .imm(8'hff));
    op(OP_ADD_MEM_A, 8'h21);
    check("ram data", wr_data, 16'h0000);
    check("alu_flags", alu_flags, 16'h0005);
    op(OP_SUB_MEM_A, 8'h21);
    check("alu_flags", alu_flags, 16'h0000);
    op(OP_MOV_MEM_IMM, 8'h21, 8'h80);
    op(OP_MOV_A_IMM, .imm(8'h80));
    op(OP_ROT_LEFT, 8'h21);
    check("carry", alu_flags & 8'h04, 16'h0004);
    op(OP_MOV_MEM_IMM, 8'h21, 8'h40);
    op(OP_MOV_A_IMM, .imm(8'h40));
    op(OP_ROT_LEFT, 8'h21);
    check("carry", alu_flags & 8'h04, 16'h0000);
    op(OP_MOV_MEM_IMM, REG_ALU_FLAGS, 8'hff);
    check("alu_flags", alu_flags, 16'h0005);
  endtask

  task automatic t_pointers();
    op(OP_MOV_MEM_IMM, REG_INDEX_HIGH, 8'h02);
    op(OP_MOV_MEM_IMM, REG_INDEX_LOW, 8'h40);
    check("index", {index_high, index_low}, 16'h0240);
    op(OP_MOV_A_IMM, .imm(8'h77));
    op(OP_MOV_MEM_A, .ind(1'b1));
    check("ram write", wr_addr, 16'h0240);
    op(OP_MOV_A_IMM, .imm(8'h66));
    op(OP_MOV_MEM_A, REG_INDEXED_CELL);
    check("ram write", wr_addr, 16'h0240);
    check("ram data", wr_data, 16'h0066);
    op(OP_MOV_A_MEM, REG_INDEX_LOW);
    check("accumulator", accumulator, 16'h0040);
    op(OP_MOV_MEM_IMM, REG_TABLE_HIGH_LATCH, 8'h9c);
    check("table_high_latch", table_high_latch, 16'h009c);
    op(OP_TABLE_FETCH);
    check("rom address", seen_rom, 16'h0240);
    check("table word", {table_high_latch, accumulator}, 16'hbf42);
  endtask

  task automatic t_location_write();
    op(OP_JUMP, .tgt(11'h3f0));
    op(OP_MOV_A_IMM, .imm(8'h20));
    op(OP_ADD_MEM_A, REG_LOC_LOW_HALF);
    check("fetch_location", fetch_location, 16'h0411);
    op(OP_SUB_MEM_A, REG_LOC_LOW_HALF);
    check("fetch_location", fetch_location, 16'h04f1);
    op(OP_MOV_A_IMM, .imm(8'h28));
    op(OP_MOV_MEM_A, REG_LOC_LOW_HALF);
    check("fetch_location", fetch_location, 16'h0428);
    op(OP_MOV_MEM_IMM, REG_LOC_HIGH_HALF, 8'h05);
    check("fetch_location", fetch_location, 16'h0529);
  endtask

  task automatic t_stack();
    op(OP_CALL, .tgt(11'h100));
    check("call", {stack_pointer, 3'h0, fetch_location}, 16'h8100);
    op(OP_CALL, .tgt(11'h200));
    check("call", {stack_pointer, 3'h0, fetch_location}, 16'h4200);
    op(OP_RET);
    check("return", {stack_pointer, 3'h0, fetch_location}, 16'h8101);
    op(OP_RET);
    check("return", {stack_pointer, 3'h0, fetch_location}, 16'hc52a);
  endtask

  // call and return taken on two consecutive edges, valid held high between them
  task automatic t_back_to_back();
    logic [10:0] loc;
    loc = fetch_location;
    @(posedge ref_clk);
    req <= '{valid: 1'b1, op: OP_CALL, indirect: 1'b0, addr: 8'h00, imm: 8'h00,
             bit_sel: 3'h0, target: 11'h155};
    @(posedge ref_clk);
    req.op <= OP_RET;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    @(negedge ref_clk);
    check("return", {stack_pointer, 3'h0, fetch_location}, {2'h3, 3'h0, loc + 11'h1});
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_jump();
    t_compare();
    t_skips();
    t_alu();
    t_pointers();
    t_location_write();
    t_stack();
    t_back_to_back();
    // a second reset in mid-run must bring location, pointer and flags back
    op(OP_CALL, .tgt(11'h155));
    op(OP_CMP_SKIP_IMM, .imm(8'h28));
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    t_reset();
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    t_reset();
    op(OP_NOP);
    check("fetch_location", fetch_location, 16'h0001);
    test_done();
  end
endmodule
